/* design/see_engine.sv */
// Serial EEPROM command engine: bus slave, page buffer, program timer
`timescale 1ns/100ps
module see_engine
  import see_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Straps and protection
  input  wire logic [2:0] chip_select_straps,
  input  wire logic       write_lock,
  // Status
  output logic            prog_busy
);

  localparam int PCW = $clog2(PROG_CYCLES_P + 1);

  // Storage arrays, no reset
  logic [7:0]        mem_array [MEM_BYTES];
  logic [7:0]        page_buf  [PAGE_BYTES];

  // Synchroniser stages
  see_pins_s         sync1_reg;
  see_pins_s         sync2_reg;
  see_pins_s         sync3_reg;
  see_pins_s         pins_now;

  // Protocol state
  see_state_e        state_reg,    state_next;
  logic [3:0]        cnt_reg,      cnt_next;
  logic [7:0]        shift_reg,    shift_next;
  logic [ADDR_W-1:0] addr_reg,     addr_next;
  logic              oe_reg,       oe_next;
  logic              rw_reg,       rw_next;
  logic              hack_reg,     hack_next;
  logic              pend_reg,     pend_next;
  logic [PAGE_BYTES-1:0] valid_reg, valid_next;
  logic              buf_we;

  // Program engine state
  logic              busy_reg,     busy_next;
  logic [6:0]        idx_reg,      idx_next;
  logic [PCW-1:0]    pcnt_reg,     pcnt_next;
  logic [PAGE_W-1:0] page_reg,     page_next;
  logic              mem_we;

  // Decoded bus events
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              dev_match;
  logic [ADDR_W-1:0] addr_inc;
  logic [ADDR_W-1:0] addr_page_inc;
  logic [7:0]        rd_cur;
  logic [7:0]        rd_inc;

  assign pins_now.scl  = scl_in;
  assign pins_now.sda  = sda_in;
  assign pins_now.lock = write_lock;
  assign pins_now.cs   = chip_select_straps;

  // Two-stage sync plus one history stage for edge finding
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_reg <= '{scl: 1'b1, sda: 1'b1, lock: 1'b1, cs: 3'h0};
      sync2_reg <= '{scl: 1'b1, sda: 1'b1, lock: 1'b1, cs: 3'h0};
      sync3_reg <= '{scl: 1'b1, sda: 1'b1, lock: 1'b1, cs: 3'h0};
    end else begin
      sync1_reg <= pins_now;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Edges and start/stop, all from settled stages
  assign scl_rise  = sync2_reg.scl & ~sync3_reg.scl;
  assign scl_fall  = ~sync2_reg.scl & sync3_reg.scl;
  assign start_det = sync2_reg.scl & sync3_reg.scl &
                     sync3_reg.sda & ~sync2_reg.sda;
  assign stop_det  = sync2_reg.scl & sync3_reg.scl &
                     ~sync3_reg.sda & sync2_reg.sda;

  // A busy device never answers its address, so polling sees a nack
  assign dev_match = (shift_reg[7:4] == DEV_TYPE) &&
                     (shift_reg[3:1] == sync2_reg.cs) && !busy_reg;

  assign addr_inc      = addr_reg + 15'h1;
  assign addr_page_inc = {addr_reg[ADDR_W-1:PAGE_OFS_W],
                          addr_reg[PAGE_OFS_W-1:0] + 6'h1};
  assign rd_cur        = mem_array[addr_reg];
  assign rd_inc        = mem_array[addr_inc];

  // Protocol next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    addr_next  = addr_reg;
    oe_next    = oe_reg;
    rw_next    = rw_reg;
    hack_next  = hack_reg;
    pend_next  = pend_reg;
    valid_next = valid_reg;
    buf_we     = 1'b0;
    if (start_det) begin
      state_next = ST_DEV;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (stop_det) begin
      // Stop always releases the line and ends any transfer
      state_next = ST_IDLE;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      pend_next  = 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise) begin
        if (cnt_reg < BIT_ACK) begin
          cnt_next = cnt_reg + 4'h1;
          if (state_reg != ST_RDATA) begin
            shift_next = {shift_reg[6:0], sync2_reg.sda};
          end
        end else if (cnt_reg == BIT_ACK) begin
          cnt_next  = BIT_END;
          hack_next = ~sync2_reg.sda;
        end
      end else if (scl_fall) begin
        if (state_reg == ST_RDATA) begin
          if (cnt_reg != 4'h0 && cnt_reg < BIT_ACK) begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next    = ~shift_reg[6];
          end else if (cnt_reg == BIT_ACK) begin
            oe_next = 1'b0;
          end else if (cnt_reg == BIT_END) begin
            // Counter moves past every byte sent, acked or not
            addr_next = addr_inc;
            cnt_next  = 4'h0;
            if (hack_reg) begin
              shift_next = rd_inc;
              oe_next    = ~rd_inc[7];
            end else begin
              state_next = ST_IDLE;
              oe_next    = 1'b0;
            end
          end
        end else if (cnt_reg == BIT_ACK) begin
          unique case (state_reg)
            ST_DEV: begin
              if (dev_match) begin
                oe_next = 1'b1;
                rw_next = shift_reg[0];
                if (!shift_reg[0]) begin
                  valid_next = '0;
                end
              end else begin
                state_next = ST_IDLE;
                cnt_next   = 4'h0;
              end
            end
            ST_ADDR_HI: begin
              // Top bit of the high byte is a don't-care
              addr_next[ADDR_W-1:8] = shift_reg[6:0];
              oe_next               = 1'b1;
            end
            ST_ADDR_LO: begin
              addr_next[7:0] = shift_reg;
              oe_next        = 1'b1;
            end
            ST_WDATA: begin
              buf_we     = 1'b1;
              valid_next[addr_reg[PAGE_OFS_W-1:0]] = 1'b1;
              addr_next  = addr_page_inc;
              pend_next  = 1'b1;
              oe_next    = 1'b1;
            end
            default: begin
              oe_next = 1'b0;
            end
          endcase
        end else if (cnt_reg == BIT_END) begin
          cnt_next = 4'h0;
          oe_next  = 1'b0;
          unique case (state_reg)
            ST_DEV: begin
              if (rw_reg) begin
                state_next = ST_RDATA;
                shift_next = rd_cur;
                oe_next    = ~rd_cur[7];
              end else begin
                state_next = ST_ADDR_HI;
              end
            end
            ST_ADDR_HI: state_next = ST_ADDR_LO;
            ST_ADDR_LO: state_next = ST_WDATA;
            default:    state_next = state_reg;
          endcase
        end
      end
    end
  end

  // Protocol registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg  <= 15'h0000;
      oe_reg    <= 1'b0;
      rw_reg    <= 1'b0;
      hack_reg  <= 1'b0;
      pend_reg  <= 1'b0;
      valid_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      oe_reg    <= oe_next;
      rw_reg    <= rw_next;
      hack_reg  <= hack_next;
      pend_reg  <= pend_next;
      valid_reg <= valid_next;
    end
  end

  // Page buffer fill; the array is only touched by the program cycle
  always_ff @(posedge clock) begin
    if (buf_we) begin
      page_buf[addr_reg[PAGE_OFS_W-1:0]] <= shift_reg;
    end
  end

  // Program engine: copy buffered bytes, then hold busy to the limit
  always_comb begin
    busy_next = busy_reg;
    idx_next  = idx_reg;
    pcnt_next = pcnt_reg;
    page_next = page_reg;
    mem_we    = 1'b0;
    if (!busy_reg) begin
      if (stop_det && pend_reg) begin
        busy_next = 1'b1;
        idx_next  = 7'h00;
        pcnt_next = '0;
        page_next = addr_reg[ADDR_W-1:PAGE_OFS_W];
      end
    end else begin
      pcnt_next = pcnt_reg + PCW'(1);
      if (!idx_reg[6]) begin
        // Lock is checked per byte, so locking during the 64-clock copy skips the bytes not yet written
        mem_we   = valid_reg[idx_reg[5:0]] & ~sync2_reg.lock;
        idx_next = idx_reg + 7'h01;
      end
      if (pcnt_reg == PCW'(PROG_CYCLES_P - 1)) begin
        busy_next = 1'b0;
      end
    end
  end

  // Program engine registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      idx_reg  <= 7'h00;
      pcnt_reg <= '0;
      page_reg <= 9'h000;
    end else begin
      busy_reg <= busy_next;
      idx_reg  <= idx_next;
      pcnt_reg <= pcnt_next;
      page_reg <= page_next;
    end
  end

  // Array write port
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem_array[{page_reg, idx_reg[5:0]}] <= page_buf[idx_reg[5:0]];
    end
  end

  // Pin and status outputs; the pin is open drain, only pulled low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      prog_busy <= 1'b0;
    end else begin
      sda_out   <= 1'b0;
      sda_oe    <= oe_reg;
      prog_busy <= busy_reg;
    end
  end

endmodule : see_engine

/* design/see_pkg.sv */
// Constants, types and the rule summary for the serial EEPROM engine
//
// How it works
// - Lock pin high: no array location is ever altered by a write.
// - Two word address bytes follow the write device word, each acked low.
// - Every received write data byte is acked low in the ninth clock.
// - Stop after write data starts program cycle; bus ignored meanwhile.
// - After each write byte only the low 6 address bits increment.
// - In-page address wraps to page start; extra bytes overwrite.
// - Device address word not acked while programming; acked afterwards.
// - Address counter keeps last accessed address plus one, in-page after a write.
// - Read counter wraps from top of array to zero, reads continue.
// - After read device ack, byte at counter shifts out next clocks.
// - Host ack low after read byte advances counter, sends next byte.
// - High ack then stop ends sequential read; device stops driving.
// - Array of 512 pages by 64 bytes, 15-bit word address.
// - Select bits compared with straps; mismatch returns to standby.
// - Program cycle ends within 5 ms of the stop.
package see_pkg;

  localparam int          ADDR_W      = 15;
  localparam int          PAGE_OFS_W  = 6;
  localparam int          PAGE_W      = 9;
  localparam int          PAGE_BYTES  = 64;
  localparam int          MEM_BYTES   = 32768;
  localparam logic [3:0]  DEV_TYPE    = 4'ha;
  localparam logic [3:0]  BIT_ACK     = 4'h8;
  localparam logic [3:0]  BIT_END     = 4'h9;

  // Program cycle limit and its cycle count at the core clock
  localparam int          PROG_TIME_MS = 5;
  localparam int          CLK_FREQ_KHZ = 25000;
  localparam int          PROG_CYCLES  = PROG_TIME_MS * CLK_FREQ_KHZ;

  // Bus protocol position
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA
  } see_state_e;

  // Pins crossing into the clock domain together
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       lock;
    logic [2:0] cs;
  } see_pins_s;

endpackage : see_pkg

/* verification/see_engine_asserts.sv */
// Port-level checks of the EEPROM engine
`timescale 1ns/100ps
module see_engine_asserts
  import see_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // Bus, straps, status
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [2:0] chip_select_straps,
  input wire logic       write_lock,
  input wire logic       prog_busy
);
  int busy_cnt_reg;
  int busy_cnt_next;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Busy length, counted rather than unrolled
  always_comb begin
    busy_cnt_next = prog_busy ? busy_cnt_reg + 1 : 0;
  end
  always_ff @(posedge clock) begin
    busy_cnt_reg <= sys_rst ? 0 : busy_cnt_next;
  end
  sequence s_busy_start; $rose(prog_busy); endsequence
  sequence s_busy_hold; prog_busy [*8]; endsequence
  property p_open_drain; sda_out == 1'b0; endproperty
  property p_busy_silent; prog_busy |-> !sda_oe; endproperty
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 3);
  endproperty
  property p_oe_stable_high; $rose(scl_in) |-> $stable(sda_oe) [*3];
  endproperty
  property p_busy_hold; s_busy_start |-> s_busy_hold; endproperty
  property p_busy_max; busy_cnt_reg <= PROG_CYCLES_P; endproperty
  property p_busy_after_stop;
    s_busy_start |-> scl_in && sda_in && $past(scl_in, 6);
  endproperty
  property p_oe_release; $rose(sda_oe) |-> ##[1:120] !sda_oe; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  a_busy_silent: assert property (p_busy_silent)
    else $error("answer while programming");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data moved outside clock low");
  a_oe_stable_high: assert property (p_oe_stable_high)
    else $error("data moved while clock high");
  a_busy_hold: assert property (p_busy_hold)
    else $error("program cycle too short");
  a_busy_max: assert property (p_busy_max)
    else $error("program cycle too long");
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("program cycle without stop");
  a_oe_release: assert property (p_oe_release)
    else $error("data line held too long");
endmodule : see_engine_asserts

/* verification/see_host.sv */
// Two-wire bus host model
`timescale 1ns/100ps
module see_host (
  // Pacing clock
  input  wire logic clk,
  // Resolved data line
  input  wire logic sda_line,
  // Host drives, data open drain
  output logic      scl,
  output logic      sda_h
);
  // Five low plus three high clocks give the 320 ns bus period
  int low_clk = 5;
  // Idle bus from time zero; clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Waits out a device ack before raising the clock
  task automatic start_c();
    // Data moves one clock after the fall, never with it
    tick(1);
    sda_h = 1'b1;
    tick(low_clk - 1);
    scl = 1'b1;
    tick(3);
    sda_h = 1'b0;
    tick(3);
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    tick(1);
    sda_h = 1'b0;
    tick(low_clk - 1);
    scl = 1'b1;
    tick(3);
    sda_h = 1'b1;
    tick(3);
  endtask : stop_c
  task automatic bit_x(input logic b, output logic r);
    tick(1);
    sda_h = b;
    tick(low_clk - 1);
    scl = 1'b1;
    tick(1);
    r = sda_line;
    tick(2);
    scl = 1'b0;
  endtask : bit_x
  // MSB first, ninth bit is the answer
  task automatic byte_w(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(v[i], ack);
    bit_x(1'b1, ack);
  endtask : byte_w
  task automatic byte_r(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(nack, r);
  endtask : byte_r
endmodule : see_host

/* verification/see_engine_bench.sv */
// Self-checking bench of the EEPROM engine
`timescale 1ns/100ps
module see_engine_bench;
  import see_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       lock = 1'b0;
  logic       scl, sda_h, sda_oe, sda_out, busy, a;
  logic [7:0] d;
  int         error_cnt = 0;
  int         n_checks = 0;
  wire        sda_line = sda_h & ~(sda_oe & ~sda_out);
  // Clock, 40 ns period
  always #20 clock = ~clock;
  see_host host (.clk(clock), .sda_line(sda_line), .scl(scl),
    .sda_h(sda_h));
  see_engine #(.PROG_CYCLES_P(200)) uut (.clock(clock),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(STRAP),
    .write_lock(lock), .prog_busy(busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // Bounded wait on the busy flag
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 400 && busy !== lvl; i++) host.tick(1);
    if (busy !== lvl) begin
      error_cnt++;
      complete_run();
    end
  endtask : wait_busy
  task automatic dev(input logic rw, input logic [2:0] cs,
                     output logic k);
    host.start_c();
    host.byte_w({DEV_TYPE, cs, rw}, k);
  endtask : dev
  task automatic wr(input logic [14:0] ad, input int n,
                    input logic [7:0] v0);
    logic k;
    dev(1'b0, STRAP, k);
    check(k, 1'b0);
    host.byte_w({1'b0, ad[14:8]}, k);
    check(k, 1'b0);
    host.byte_w(ad[7:0], k);
    check(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.byte_w(v0 + 8'(i), k);
      check(k, 1'b0);
    end
    host.stop_c();
    wait_busy(1'b1);
    dev(1'b0, STRAP, k);
    check(k, 1'b1);
    host.stop_c();
    wait_busy(1'b0);
    dev(1'b0, STRAP, k);
    check(k, 1'b0);
    host.stop_c();
  endtask : wr
  task automatic rd(input logic rnd, input logic [14:0] ad, input int n,
                    input logic [7:0] e0, input logic [7:0] e1);
    logic k;
    if (rnd) begin
      dev(1'b0, STRAP, k);
      host.byte_w({1'b0, ad[14:8]}, k);
      host.byte_w(ad[7:0], k);
    end
    dev(1'b1, STRAP, k);
    check(k, 1'b0);
    host.byte_r(n == 1, d);
    check(d, e0);
    if (n > 1) begin
      host.byte_r(1'b1, d);
      check(d, e1);
    end
    host.stop_c();
  endtask : rd
  // Main sequence
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    host.tick(4);
    dev(1'b0, 3'h2, a);
    check(a, 1'b1);
    host.stop_c();
    // Wrong device type nibble is refused as well
    host.start_c();
    host.byte_w({4'h5, STRAP, 1'b0}, a);
    check(a, 1'b1);
    host.stop_c();
    wr(15'h013f, 65, 8'h00);
    rd(1'b0, 15'h0000, 2, 8'h01, 8'h02);
    rd(1'b1, 15'h013f, 1, 8'h40, 8'h00);
    lock = 1'b1;
    wr(15'h0105, 1, 8'haa);
    lock = 1'b0;
    rd(1'b1, 15'h0105, 1, 8'h06, 8'h00);
    wr(15'h7fff, 1, 8'h5a);
    wr(15'h0000, 1, 8'ha5);
    rd(1'b1, 15'h7fff, 2, 8'h5a, 8'ha5);
    complete_run();
  end
endmodule : see_engine_bench
bind see_engine see_engine_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .chip_select_straps(chip_select_straps), .write_lock(write_lock),
  .prog_busy(prog_busy));
